// file: logic/acl_action_decoder.sv
// Action word decoder and applier with AHB-Lite control registers
`timescale 1ns/1ps
`default_nettype none
module acl_action_decoder
   import acl_action_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire lookup_s lookup,
   input wire frame_ctx_s ctx,
   input wire logic entry_rewrite,
   input wire logic [ENTRY_W-1:0] entry_rewrite_index,
   output result_s result,
   output logic hit_irq
);
   // ======================================================================
   // Action unpacking
   action_s act;
   logic applies;
   logic spent_now;
   logic one_shot_fires;
   logic copy_now;
   logic delay_cmd;
   logic [QUEUES-1:0] base_queues;
   logic [QUEUES-1:0] copy_queue;
   logic [PORT_W-1:0] redirect_mask;
   logic [PORT_W-1:0] masked_dest;
   logic masked_locked;
   logic [31:0] ctrl;
   logic [ENTRIES-1:0] spent;
   logic [HITS_W-1:0] hits;
   logic [GROUP_IDX_W-1:0] group_idx;
   logic [31:0] group_lo;
   result_s next_result;
   logic spent_wr;
   logic group_wr;

   assign act = action_s'(lookup.action);
   assign applies = lookup.valid && lookup.hit && ctrl[CTRL_ENABLE_BIT]
                    && (!ctx.terminated || act.ignore_stage_control);
   assign spent_now = spent[lookup.entry];
   assign one_shot_fires = act.one_shot_copy && !spent_now;
   assign copy_now = act.host_copy_enable || one_shot_fires;
   assign delay_cmd = act.rewriter_command[DELAY_CMD_BIT];
   assign base_queues = act.host_extract_disable ? '0 : ctx.host_queues;
   assign copy_queue = copy_now ? QUEUES'(1) << act.host_queue_num : '0;

   // ======================================================================
   // Mask handling
   port_group_table #(
      .IDX_W(GROUP_IDX_W),
      .DATA_W(PORT_W)
   ) u_group_table (
      .hclk(hclk),
      .wr_en(group_wr),
      .wr_index(group_idx),
      .wr_data({hwdata[GROUP_HI_W-1:0], group_lo}),
      .rd_index(act.port_mask[GROUP_IDX_W-1:0]),
      .rd_data(redirect_mask)
   );

   mask_apply u_mask_apply (
      .mode(act.mask_mode),
      .port_mask(act.port_mask),
      .redirect_mask(redirect_mask),
      .ctx(ctx),
      .dest_out(masked_dest),
      .locked_out(masked_locked)
   );

   // ======================================================================
   // Result assembly
   always_comb begin
      next_result = '0;
      next_result.valid = lookup.valid;
      next_result.applied = applies;
      next_result.dest_mask = ctx.dest_mask;
      next_result.locked = ctx.locked;
      next_result.host_queues = ctx.host_queues;
      next_result.stage_point = ctx.stage_point;
      if (applies) begin
         next_result.inner_point = act.inner_point_flag;
         next_result.dest_mask = masked_dest;
         next_result.locked = masked_locked;
         next_result.host_queues = base_queues | copy_queue;
         next_result.host_copy = copy_now;
         next_result.learn_block = act.learn_block;
         next_result.route_block = act.route_block;
         next_result.meter_valid = act.meter_enable;
         next_result.sip_swap_valid = !act.meter_enable;
         next_result.meter_index = act.meter_index;
         if (act.force_stage_enable) begin
            next_result.stage_forced = 1'b1;
            next_result.stage_point = act.stage_point_select;
            next_result.stage_action_none = act.stage_point_select == STAGE_NONE;
         end
         next_result.mac_exchange = act.mac_exchange_enable && !delay_cmd;
         next_result.interval_valid = delay_cmd && ctx.mc_delay_resp;
         // Exchange bit as sign makes the 4-bit value code or code minus 8
         next_result.interval = {act.mac_exchange_enable, act.msg_interval_code};
         next_result.mirror_enable = act.mirror_select != 2'h0;
         next_result.mirror_probe = act.mirror_select - 2'h1;
         next_result.rewriter_command = act.rewriter_command;
         if (delay_cmd) begin
            next_result.rewriter_command[DELAY_CMD_BIT:DELAY_CMD_LO] = 2'h0;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         result <= '0;
         hit_irq <= 1'b0;
      end else begin
         result <= next_result;
         hit_irq <= applies && act.hit_irq_enable;
      end
   end

   // ======================================================================
   // One-shot state per entry
   logic [ENTRIES-1:0] spend_set;
   logic [ENTRIES-1:0] spend_clr;
   logic [ENTRIES-1:0] next_spent;

   // With the copy bit set every frame is copied, so nothing is spent
   assign spend_set = (applies && one_shot_fires && !act.host_copy_enable)
                      ? ENTRIES'(1) << lookup.entry : '0;
   assign spend_clr = (entry_rewrite ? ENTRIES'(1) << entry_rewrite_index : '0)
                      | (spent_wr ? hwdata[ENTRIES-1:0] : '0);
   assign next_spent = (spent & ~spend_clr) | spend_set;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         spent <= '0;
         hits <= '0;
      end else begin
         spent <= next_spent;
         hits <= hits + HITS_W'(applies);
      end
   end

   // ======================================================================
   // AHB-Lite slave, zero wait states
   logic addr_ok;
   logic [7:0] wr_addr;
   logic wr_pend;
   logic ctrl_wr;
   logic group_idx_wr;
   logic group_lo_wr;
   logic [31:0] next_rdata;

   assign addr_ok = hsel && htrans[1] && hready;
   assign ctrl_wr = wr_pend && wr_addr == REG_CTRL;
   assign spent_wr = wr_pend && wr_addr == REG_SPENT;
   assign group_idx_wr = wr_pend && wr_addr == REG_GROUP_IDX;
   assign group_lo_wr = wr_pend && wr_addr == REG_GROUP_LO;
   assign group_wr = wr_pend && wr_addr == REG_GROUP_HI;

   // Read data is prepared in the address phase; a read straight after a
   // write to the same register would see the old value
   always_comb begin
      if (haddr[7:0] == REG_CTRL) begin
         next_rdata = ctrl;
      end else if (haddr[7:0] == REG_SPENT) begin
         next_rdata = 32'(spent);
      end else if (haddr[7:0] == REG_HITS) begin
         next_rdata = hits;
      end else if (haddr[7:0] == REG_GROUP_IDX) begin
         next_rdata = 32'(group_idx);
      end else if (haddr[7:0] == REG_GROUP_LO) begin
         next_rdata = group_lo;
      end else begin
         next_rdata = 32'h0000_0000;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend <= 1'b0;
         wr_addr <= 8'h00;
         hrdata <= 32'h0000_0000;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         wr_pend <= addr_ok && hwrite;
         wr_addr <= haddr[7:0];
         if (addr_ok && !hwrite) begin
            hrdata <= next_rdata;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl <= CTRL_RESET;
         group_idx <= '0;
         group_lo <= 32'h0000_0000;
      end else begin
         if (ctrl_wr) begin
            ctrl <= {31'h0000_0000, hwdata[CTRL_ENABLE_BIT]};
         end
         if (group_idx_wr) begin
            group_idx <= hwdata[GROUP_IDX_W-1:0];
         end
         if (group_lo_wr) begin
            group_lo <= hwdata;
         end
      end
   end

   // ======================================================================
   // Checks
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   sequence one_shot_fired;
      applies && one_shot_fires && !act.host_copy_enable && !entry_rewrite;
   endsequence

   // Lookups of one entry are seldom back to back, so the spent state is checked directly
   sequence spent_entry_hit;
      applies && act.one_shot_copy && !act.host_copy_enable && spent_now;
   endsequence

   a_one_shot_spent: assert property (
      one_shot_fired |=> spent[$past(lookup.entry)])
      else $error("Fired one-shot entry not held as spent");

   a_spent_no_copy: assert property (
      spent_entry_hit |=> !result.host_copy)
      else $error("Spent one-shot entry copied again");

   a_copy_queue_bit: assert property (
      applies && act.host_copy_enable |=>
         result.host_copy && result.host_queues[$past(act.host_queue_num)])
      else $error("Host copy missing on selected queue");

   a_extract_cancel: assert property (
      applies && act.host_extract_disable && !copy_now |=> result.host_queues == '0)
      else $error("Earlier host queues not cancelled");

   a_irq_on_hit: assert property (
      applies && act.hit_irq_enable |=> hit_irq ##1 !hit_irq || $past(applies))
      else $error("Hit interrupt missing");

   a_stage_force: assert property (
      applies && act.force_stage_enable |=>
         result.stage_point == $past(act.stage_point_select)
         && result.stage_action_none == ($past(act.stage_point_select) == STAGE_NONE))
      else $error("Forced stage point not applied");

   a_terminated_skip: assert property (
      lookup.valid && ctx.terminated && !act.ignore_stage_control |=> !result.applied)
      else $error("Terminated frame was acted on");

   a_interval_code: assert property (
      applies && delay_cmd && ctx.mc_delay_resp |=>
         result.interval_valid && $signed(result.interval)
            == $signed({1'b0, $past(act.msg_interval_code)})
               - (($past(act.mac_exchange_enable)) ? 5'sd8 : 5'sd0))
      else $error("Message interval wrongly encoded");

   a_lock_hold: assert property (
      applies && ctx.locked |=> result.locked
         && result.dest_mask == $past(ctx.dest_mask))
      else $error("Locked destination mask was altered");

   a_mirror_probe: assert property (
      applies && act.mirror_select == 2'h3 |=> result.mirror_enable
         && result.mirror_probe == 2'h2)
      else $error("Mirror probe selection wrong");

   a_meter_reuse: assert property (
      applies |=> result.meter_valid != result.sip_swap_valid)
      else $error("Meter and address swap both chosen");
endmodule : acl_action_decoder
`default_nettype wire

// file: logic/acl_action_pkg.sv
// Package: constants, field layout and carrier types of the action decoder
// ==========================================================================
// Notes on behaviour
// - One 196-bit action format, applied whatever key type produced the hit.
// - Fields packed contiguously in fixed order, first field at bit 0.
// - One flag marks the action as belonging to the inner-switch stage.
// - Force bit applies the stage point unconditionally; point none sets action none.
// - Stage point is 5 bits; codes 0..16 are none then sixteen stages to done.
// - One-shot bit copies the next matching frame; with copy bit every frame.
// - Interrupt-enable bit raises an interrupt on every hit of the entry.
// - Copy bit copies the frame to the host on the 3-bit queue number.
// - Extract-disable cancels earlier host queues, then this copy request applies.
// - Separate bits block address learning and block routing.
// - Meter-enable meters the frame with the 5-bit meter index.
// - Meter-enable clear reuses the index to pick a replacement source IP.
// - Ignore-control bit applies the action even to frames already terminated.
// - Delay processing: interval is the code, or code minus 8 with exchange bit.
// - Mask mode 0 OR, 1 AND with VLAN, 2 replace group mask, 3 replace all.
// - Replace-all locks the destination mask against later steps.
// - Mode 4 redirects via group table at mask bits 7:0 and locks.
// - Mode 5 ORs with the MAC group mask; 6, 7 reserved; host port untouched.
// - Port mask 55 bits; in redirect, bits 52, 51, 50 AND source, aggr, VLAN.
// - Mirror code 0 none, codes 1..3 select probes 0..2.
// - Exchange bit swaps MAC addresses unless delay processing is on.
package acl_action_pkg;
   // ======================================================================
   // Widths
   localparam int ACTION_W = 196;
   localparam int PORT_W = 55;
   localparam int STAGE_W = 5;
   localparam int QUEUE_W = 3;
   localparam int QUEUES = 8;
   localparam int METER_W = 5;
   localparam int ENTRY_W = 5;
   localparam int ENTRIES = 32;
   localparam int GROUP_IDX_W = 8;
   localparam int HITS_W = 32;
   // ======================================================================
   // Field positions and codes
   localparam logic [STAGE_W-1:0] STAGE_NONE = 5'h00;
   localparam logic [STAGE_W-1:0] STAGE_DONE = 5'h10;
   localparam int SRC_AND_BIT = 52;
   localparam int AGGR_AND_BIT = 51;
   localparam int VLAN_AND_BIT = 50;
   localparam int DELAY_CMD_BIT = 5;
   localparam int DELAY_CMD_LO = 4;
   localparam int CTRL_ENABLE_BIT = 0;
   localparam int GROUP_HI_W = PORT_W - 32;
   typedef enum logic [2:0] {
      MM_OR_DEST = 3'h0, MM_AND_VLAN = 3'h1, MM_REPLACE_GROUP = 3'h2,
      MM_REPLACE_ALL = 3'h3, MM_REDIRECT = 3'h4, MM_OR_GROUP = 3'h5
   } mask_mode_e;
   // ======================================================================
   // Register map (byte addresses) and reset values
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_SPENT = 8'h04;
   localparam logic [7:0] REG_HITS = 8'h08;
   localparam logic [7:0] REG_GROUP_IDX = 8'h0c;
   localparam logic [7:0] REG_GROUP_LO = 8'h10;
   localparam logic [7:0] REG_GROUP_HI = 8'h14;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
   // ======================================================================
   // Carriers
   typedef struct packed {
      logic [53:0] spare;
      logic mac_exchange_enable;
      logic [46:0] later_fields;
      logic [7:0] rewriter_command;
      logic [1:0] mirror_select;
      logic [PORT_W-1:0] port_mask;
      logic [2:0] mask_mode;
      logic [2:0] msg_interval_code;
      logic ignore_stage_control;
      logic [METER_W-1:0] meter_index;
      logic meter_enable;
      logic route_block;
      logic learn_block;
      logic host_extract_disable;
      logic [QUEUE_W-1:0] host_queue_num;
      logic host_copy_enable;
      logic hit_irq_enable;
      logic one_shot_copy;
      logic [STAGE_W-1:0] stage_point_select;
      logic force_stage_enable;
      logic inner_point_flag;
   } action_s;
   typedef struct packed {
      logic valid;
      logic hit;
      logic [ENTRY_W-1:0] entry;
      logic [ACTION_W-1:0] action;
   } lookup_s;
   typedef struct packed {
      logic terminated;
      logic mc_delay_resp;
      logic locked;
      logic [PORT_W-1:0] dest_mask;
      logic [PORT_W-1:0] vlan_mask;
      logic [PORT_W-1:0] group_mask;
      logic [PORT_W-1:0] src_mask;
      logic [PORT_W-1:0] aggr_mask;
      logic [QUEUES-1:0] host_queues;
      logic [STAGE_W-1:0] stage_point;
   } frame_ctx_s;
   typedef struct packed {
      logic valid;
      logic applied;
      logic inner_point;
      logic [PORT_W-1:0] dest_mask;
      logic locked;
      logic [QUEUES-1:0] host_queues;
      logic host_copy;
      logic learn_block;
      logic route_block;
      logic meter_valid;
      logic sip_swap_valid;
      logic [METER_W-1:0] meter_index;
      logic stage_forced;
      logic stage_action_none;
      logic [STAGE_W-1:0] stage_point;
      logic mac_exchange;
      logic interval_valid;
      logic [3:0] interval;
      logic mirror_enable;
      logic [1:0] mirror_probe;
      logic [7:0] rewriter_command;
   } result_s;
endpackage : acl_action_pkg

// file: logic/port_group_table.sv
// Port-group table: software-written masks read by redirect index
`timescale 1ns/1ps
`default_nettype none
module port_group_table
   import acl_action_pkg::*;
#(
   parameter int IDX_W = GROUP_IDX_W,
   parameter int DATA_W = PORT_W
) (
   input wire logic hclk,
   input wire logic wr_en,
   input wire logic [IDX_W-1:0] wr_index,
   input wire logic [DATA_W-1:0] wr_data,
   input wire logic [IDX_W-1:0] rd_index,
   output logic [DATA_W-1:0] rd_data
);
   // Not reset: software fills entries before pointing actions at them
   logic [DATA_W-1:0] table_mem [0:(1<<IDX_W)-1];

   always_ff @(posedge hclk) begin
      if (wr_en) begin
         table_mem[wr_index] <= wr_data;
      end
   end

   assign rd_data = table_mem[rd_index];
endmodule : port_group_table
`default_nettype wire

// file: logic/mask_apply.sv
// Destination mask combiner for the mask modes
`timescale 1ns/1ps
`default_nettype none
module mask_apply
   import acl_action_pkg::*;
(
   input wire logic [2:0] mode,
   input wire logic [PORT_W-1:0] port_mask,
   input wire logic [PORT_W-1:0] redirect_mask,
   input wire frame_ctx_s ctx,
   output logic [PORT_W-1:0] dest_out,
   output logic locked_out
);
   logic [PORT_W-1:0] src_term;
   logic [PORT_W-1:0] aggr_term;
   logic [PORT_W-1:0] vlan_term;
   logic [PORT_W-1:0] redirected;

   assign src_term = port_mask[SRC_AND_BIT] ? ctx.src_mask : '1;
   assign aggr_term = port_mask[AGGR_AND_BIT] ? ctx.aggr_mask : '1;
   assign vlan_term = port_mask[VLAN_AND_BIT] ? ctx.vlan_mask : '1;
   assign redirected = redirect_mask & src_term & aggr_term & vlan_term;

   // Host queues travel apart from these masks, so no mode touches them
   always_comb begin
      dest_out = ctx.dest_mask;
      locked_out = ctx.locked;
      if (!ctx.locked) begin
         case (mode)
            MM_OR_DEST: dest_out = ctx.dest_mask | port_mask;
            MM_AND_VLAN: dest_out = ctx.dest_mask & ctx.vlan_mask & port_mask;
            MM_REPLACE_GROUP: dest_out = (ctx.dest_mask & ~ctx.group_mask) | port_mask;
            MM_REPLACE_ALL: begin
               dest_out = port_mask;
               locked_out = 1'b1;
            end
            MM_REDIRECT: begin
               dest_out = redirected;
               locked_out = 1'b1;
            end
            MM_OR_GROUP: dest_out = ctx.dest_mask | port_mask | ctx.group_mask;
            default: dest_out = ctx.dest_mask;
         endcase
      end
   end
endmodule : mask_apply
`default_nettype wire

// file: tb/lookup_engine_model.sv
// Lookup engine stand-in feeding one action word and frame context per request
`timescale 1ns/1ps
`default_nettype none
module lookup_engine_model
   import acl_action_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic req,
   input wire logic req_hit,
   input wire logic [ENTRY_W-1:0] req_entry,
   input wire action_s req_action,
   input wire frame_ctx_s req_ctx,
   output lookup_s lookup,
   output frame_ctx_s ctx
);
   // ======================================================================
   // Presentation
   // Idle lines other than valid invert every cycle; valid stays low so stale words are never mistaken for data
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         lookup <= '0;
         ctx <= '0;
      end else if (req) begin
         lookup <= {1'b1, req_hit, req_entry, req_action};
         ctx <= req_ctx;
      end else begin
         lookup <= {1'b0, ~lookup[ACTION_W+ENTRY_W:0]};
         ctx <= ~ctx;
      end
   end
endmodule : lookup_engine_model
`default_nettype wire

// file: tb/acl_action_decoder_tb_top.sv
// Self-checking testbench of the action decoder
`timescale 1ns/1ps
`default_nettype none
module acl_action_decoder_tb_top
   import acl_action_pkg::*;
;
   // ======================================================================
   // Signals
   logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, hit_irq;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic req, req_hit, entry_rewrite, ctrl_en;
   logic [ENTRY_W-1:0] req_entry, entry_rewrite_index;
   action_s req_action;
   frame_ctx_s req_ctx;
   lookup_s lookup;
   frame_ctx_s ctx;
   result_s result;
   logic [ENTRIES-1:0] spent;
   logic [PORT_W-1:0] grp;
   logic [7:0] gidx;
   int num_errors, n_tests, hits, cycles;
   assign hready = hreadyout;
   acl_action_decoder u_acl_action_decoder (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .lookup(lookup), .ctx(ctx), .entry_rewrite(entry_rewrite),
      .entry_rewrite_index(entry_rewrite_index), .result(result), .hit_irq(hit_irq));
   lookup_engine_model u_lookup_engine_model (.hclk(hclk), .hresetn(hresetn), .req(req),
      .req_hit(req_hit), .req_entry(req_entry), .req_action(req_action),
      .req_ctx(req_ctx), .lookup(lookup), .ctx(ctx));
   initial begin
      hclk = 1'b0;
      forever #20 hclk = ~hclk;
   end
   // ======================================================================
   // Checking and closing
   task automatic check(input string name, input logic [127:0] seen, input logic [127:0] exp);
      n_tests++;
      if (seen !== exp) begin
         num_errors++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   task automatic results();
      $display("checks %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : results
   // A hang anywhere is cut short here
   always @(posedge hclk) begin
      cycles++;
      if (cycles == 20000) begin
         num_errors++;
         results();
      end
   end
   // ======================================================================
   // Register bus
   task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
      output logic [31:0] rd);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= wr;
      @(posedge hclk);
      while (!hready) @(posedge hclk);
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= wd;
      @(posedge hclk);
      while (!hready) @(posedge hclk);
      rd = hrdata;
      check("hresp", hresp, 1'b0);
   endtask : ahb
   task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] x;
      ahb(1'b1, a, d, x);
   endtask : reg_wr
   task automatic reg_chk(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] x;
      ahb(1'b0, a, 32'h0, x);
      check("register", x, exp);
   endtask : reg_chk
   // ======================================================================
   // Expected result of one lookup
   function automatic result_s expect_res(action_s a, frame_ctx_s c, logic hit, logic sp);
      result_s r;
      logic [PORT_W-1:0] all;
      all = '1;
      r = '0;
      r.valid = 1'b1;
      r.dest_mask = c.dest_mask;
      r.locked = c.locked;
      r.host_queues = c.host_queues;
      r.stage_point = c.stage_point;
      r.applied = hit & ctrl_en & (!c.terminated | a.ignore_stage_control);
      if (!r.applied) return r;
      r.inner_point = a.inner_point_flag;
      r.host_copy = a.host_copy_enable | (a.one_shot_copy & !sp);
      if (a.host_extract_disable) r.host_queues = '0;
      if (r.host_copy) r.host_queues[a.host_queue_num] = 1'b1;
      r.learn_block = a.learn_block;
      r.route_block = a.route_block;
      r.meter_valid = a.meter_enable;
      r.sip_swap_valid = !a.meter_enable;
      r.meter_index = a.meter_index;
      r.stage_forced = a.force_stage_enable;
      if (a.force_stage_enable) begin
         r.stage_point = a.stage_point_select;
         r.stage_action_none = (a.stage_point_select == STAGE_NONE);
      end
      r.rewriter_command = a.rewriter_command & (a.rewriter_command[5] ? 8'hcf : 8'hff);
      r.mac_exchange = a.mac_exchange_enable & !a.rewriter_command[5];
      r.interval_valid = c.mc_delay_resp & a.rewriter_command[5];
      r.interval = {a.mac_exchange_enable, a.msg_interval_code};
      r.mirror_enable = (a.mirror_select != 2'h0);
      r.mirror_probe = a.mirror_select - 2'h1;
      if (!c.locked) begin
         case (a.mask_mode)
            3'h0: r.dest_mask = c.dest_mask | a.port_mask;
            3'h1: r.dest_mask = c.dest_mask & c.vlan_mask & a.port_mask;
            3'h2: r.dest_mask = (c.dest_mask & ~c.group_mask) | a.port_mask;
            3'h3: r.dest_mask = a.port_mask;
            3'h4: r.dest_mask = grp & (a.port_mask[SRC_AND_BIT] ? c.src_mask : all)
               & (a.port_mask[AGGR_AND_BIT] ? c.aggr_mask : all)
               & (a.port_mask[VLAN_AND_BIT] ? c.vlan_mask : all);
            3'h5: r.dest_mask = c.dest_mask | a.port_mask | c.group_mask;
            default: r.dest_mask = c.dest_mask;
         endcase
         r.locked = (a.mask_mode == 3'h3) || (a.mask_mode == 3'h4);
      end
      return r;
   endfunction : expect_res
   // ======================================================================
   // Lookup driver
   task automatic run_lookup(input logic hit, input logic [4:0] e, input action_s a,
      input frame_ctx_s c);
      result_s exp;
      result_s got;
      exp = expect_res(a, c, hit, spent[e]);
      @(posedge hclk);
      req <= 1'b1;
      req_hit <= hit;
      req_entry <= e;
      req_action <= a;
      req_ctx <= c;
      @(posedge hclk);
      req <= 1'b0;
      @(posedge hclk);
      #1;
      got = result;
      if (!exp.interval_valid) begin
         got.interval = '0;
         exp.interval = '0;
      end
      check("result", got, exp);
      check("hit_irq", hit_irq, exp.applied & a.hit_irq_enable);
      if (exp.applied && a.one_shot_copy && !a.host_copy_enable) spent[e] = 1'b1;
      if (exp.applied) hits++;
   endtask : run_lookup
   task automatic run_random(input logic force_hit);
      logic [319:0] w;
      action_s a;
      w = {$urandom, $urandom, $urandom, $urandom, $urandom, $urandom, $urandom,
         $urandom, $urandom, $urandom};
      a = w[ACTION_W-1:0];
      if (a.mask_mode == 3'h4) a.port_mask[7:0] = gidx;
      run_lookup(force_hit | w[300], w[305:301], a, w[319:29]);
   endtask : run_random
   // ======================================================================
   // Main sequence
   initial begin
      action_s a;
      hresetn = 1'b0;
      {hsel, hwrite, req, req_hit, entry_rewrite} = '0;
      {haddr, hwdata, req_entry, entry_rewrite_index} = '0;
      htrans = 2'h0;
      hsize = 3'h2;
      req_action = '0;
      req_ctx = '0;
      {num_errors, n_tests, hits, cycles} = '0;
      spent = '0;
      ctrl_en = 1'b1;
      void'($urandom(76));
      repeat (6) @(posedge hclk);
      hresetn <= 1'b1;
      reg_chk(REG_CTRL, CTRL_RESET);
      reg_chk(REG_SPENT, 32'h0);
      reg_chk(REG_HITS, 32'h0);
      reg_chk(8'h20, 32'h0);
      $display("test register reset done");
      gidx = 8'($urandom);
      grp = {23'($urandom), $urandom};
      reg_wr(REG_GROUP_IDX, {24'h0, gidx});
      reg_wr(REG_GROUP_LO, grp[31:0]);
      reg_wr(REG_GROUP_HI, {9'h0, grp[54:32]});
      for (int i = 0; i < 300; i++) run_random(1'b0);
      $display("test random lookups done");
      reg_wr(REG_SPENT, 32'hffff_ffff);
      spent = '0;
      reg_chk(REG_SPENT, 32'h0);
      a = '0;
      a.one_shot_copy = 1'b1;
      a.host_queue_num = 3'h5;
      repeat (2) run_lookup(1'b1, 5'h3, a, '0);
      reg_chk(REG_SPENT, 32'h8);
      @(posedge hclk);
      entry_rewrite <= 1'b1;
      entry_rewrite_index <= 5'h3;
      @(posedge hclk);
      entry_rewrite <= 1'b0;
      spent[3] = 1'b0;
      run_lookup(1'b1, 5'h3, a, '0);
      a.host_copy_enable = 1'b1;
      a.host_extract_disable = 1'b1;
      a.ignore_stage_control = 1'b1;
      repeat (2) run_lookup(1'b1, 5'h4, a, '1);
      $display("test one-shot copy done");
      reg_wr(REG_CTRL, 32'h0);
      ctrl_en = 1'b0;
      reg_chk(REG_CTRL, 32'h0);
      run_random(1'b1);
      reg_wr(REG_CTRL, 32'h1);
      ctrl_en = 1'b1;
      run_random(1'b1);
      reg_chk(REG_HITS, 32'(hits));
      $display("test control and counter done");
      results();
   end
endmodule : acl_action_decoder_tb_top
`default_nettype wire
